// [acs_pkg.sv]
// acs_pkg: register map, field layout, timing counts and decode functions
// for the converter sequencer. assumes a 40 MHz system clock on aclk.
package acs_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_TIMING  = 8'h04;
  localparam logic [7:0] REG_RES_HI  = 8'h08;
  localparam logic [7:0] REG_RES_LO  = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_PORT    = 8'h14;
  localparam logic [7:0] REG_PINCFG  = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int TIM_FMT_BIT   = 7;
  localparam int TIM_ACQ_LSB   = 3;
  localparam int TIM_CLK_LSB   = 0;
  localparam int STAT_FLAG_BIT = 0;

  // reset values
  localparam logic [2:0] ACQ_SEL_RST = 3'h0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing
  localparam int CLK_NS     = 25;
  localparam int RC_TAD_NS  = 1200;
  localparam int RC_TAD_CYC = (RC_TAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TCY_OSC    = 4;
  localparam logic [4:0] TCY_LAST  = 5'(TCY_OSC - 1);
  localparam logic [3:0] CONV_LAST = 4'hA;
  localparam logic [4:0] WAIT_LAST = 5'h01;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_DISCH = 7'h02,
    ST_SAMPL = 7'h04,
    ST_HOLD  = 7'h08,
    ST_ACQ   = 7'h10,
    ST_CONV  = 7'h20,
    ST_WAIT2 = 7'h40
  } acs_state_e;

  // last count of one bit period, in aclk cycles
  function automatic logic [6:0] tad_last(input logic [2:0] sel);
    case (sel)
      3'h0:    tad_last = 7'h01;
      3'h4:    tad_last = 7'h03;
      3'h1:    tad_last = 7'h07;
      3'h5:    tad_last = 7'h0F;
      3'h2:    tad_last = 7'h1F;
      3'h6:    tad_last = 7'h3F;
      default: tad_last = 7'(RC_TAD_CYC - 1);
    endcase
  endfunction : tad_last

  // acquisition length in bit periods
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0C;
      3'h6:    acq_tads = 5'h10;
      3'h7:    acq_tads = 5'h14;
      default: acq_tads = 5'h00;
    endcase
  endfunction : acq_tads

  // set bits mark pins configured as analog inputs
  function automatic logic [15:0] analog_mask(input logic [3:0] cfg);
    int dig;
    dig = (cfg == 4'h0) ? 0 : int'(cfg) + 1;
    for (int i = 0; i < 16; i++) begin
      analog_mask[i] = (i < 16 - dig);
    end
  endfunction : analog_mask

endpackage : acs_pkg

// [acs_tad_gen.sv]
// acs_tad_gen: bit period tick generator from the system clock or the rc rate.
// assumes restart comes from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module acs_tad_gen
  import acs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       restart,
  input  wire logic [2:0] clk_sel,
  output logic            tick
);

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;

  // tick ends each bit period; restart aligns the period to a phase start
  always_comb begin
    // at or past the last count, so a shorter period chosen mid-count ends at once
    tick = (cnt_r >= tad_last(clk_sel));
    if (restart || tick) begin
      cnt_nxt = 7'h00;
    end else begin
      cnt_nxt = cnt_r + 7'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : acs_tad_gen
`default_nettype wire

// [acs_top.sv]
// acs_top: axi4-lite register file and acquisition/conversion sequencer.
// assumes comp_hi and pin_in are asynchronous pins; axi master is on aclk.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - start with acq set samples, then converts
// - manual mode starts conversion at once, except with the rc clock
// - acquisition field resets to zero
// - completion clears start, sets flag, resamples
// - no acquisition or conversion phase status
// - conversion takes exactly eleven bit periods
// - clock select gives bit period
// - manual rc start waits one instruction
// - analog pins read low on port
// - clearing start aborts, result kept
// - two bit periods before acquisition restarts
// - capacitor disconnected when conversion begins
// - discharge array before every sampling period
// - setting 010 gives four period acquisition
// - acquisition field encodes zero to twenty
// - result justified by format bit
// - reset turns converter off, aborts
module acs_top
  import acs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        comp_hi,
  input  wire logic [15:0] pin_in,
  output logic             cap_connect,
  output logic             array_discharge,
  output logic [9:0]       sar_trial,
  output logic [3:0]       channel_select,
  output logic             conv_complete_flag
);

  // bus state
  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [7:0]  waddr_r, waddr_nxt, wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_fire;
  logic [7:0]  rd8;
  logic        rd_hit, wr_hit;
  // sequencer state
  acs_state_e  state_r, state_nxt;
  logic        converter_enable_r, converter_enable_nxt, go_r, go_nxt;
  logic [3:0]  chan_r, chan_nxt, pincfg_r, pincfg_nxt;
  logic        fmt_r, fmt_nxt, flag_r, flag_nxt;
  logic [2:0]  acq_sel_r, acq_sel_nxt, clk_sel_r, clk_sel_nxt;
  logic [7:0]  res_hi_r, res_hi_nxt, res_lo_r, res_lo_nxt;
  logic [4:0]  ph_cnt_r, ph_cnt_nxt;
  logic [3:0]  conv_cnt_r, conv_cnt_nxt;
  logic [9:0]  sar_r, sar_nxt;
  logic        cap_r, cap_nxt, dis_r, dis_nxt;
  logic        tad_tick, tad_restart, res_wr;
  logic [3:0]  bit_idx;
  // pin synchronisers
  logic [16:0] sync1_r, sync2_r;

  // two-flop synchronisers for comparator and port pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 17'h0_0000;
      sync2_r <= 17'h0_0000;
    end else begin
      sync1_r <= {comp_hi, pin_in};
      sync2_r <= sync1_r;
    end
  end

  acs_tad_gen u_tad (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (tad_restart),
    .clk_sel (clk_sel_r),
    .tick    (tad_tick)
  );

  // axi4-lite handshakes, write commit and read mux
  always_comb begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    wr_fire     = aw_held_r && w_held_r && !bvalid_r;
    wr_hit      = (waddr_r <= REG_PINCFG) && (waddr_r[1:0] == 2'h0) && (waddr_r != REG_PORT);
    rd_hit      = 1'b1;
    case (s_axi_araddr)
      REG_CTRL:   rd8 = {2'h0, chan_r, go_r, converter_enable_r};
      REG_TIMING: rd8 = {fmt_r, 1'b0, acq_sel_r, clk_sel_r};
      REG_RES_HI: rd8 = res_hi_r;
      REG_RES_LO: rd8 = res_lo_r;
      REG_STATUS: rd8 = {7'h00, flag_r};
      REG_PINCFG: rd8 = {4'h0, pincfg_r};
      REG_PORT:   rd8 = 8'h00;
      default: begin
        rd8    = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_awvalid && awready_r) begin
      awready_nxt = 1'b0;
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      wready_nxt = 1'b0;
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata[7:0];
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == REG_PORT) begin
        rdata_nxt = {16'h0000, sync2_r[15:0] & ~analog_mask(pincfg_r)};
      end else begin
        rdata_nxt = {24'h00_0000, rd8};
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // software writes first, then the sequencer, which wins where both act
  always_comb begin
    state_nxt            = state_r;
    converter_enable_nxt = converter_enable_r;
    go_nxt               = go_r;
    chan_nxt             = chan_r;
    pincfg_nxt           = pincfg_r;
    fmt_nxt              = fmt_r;
    flag_nxt             = flag_r;
    acq_sel_nxt          = acq_sel_r;
    clk_sel_nxt          = clk_sel_r;
    res_hi_nxt           = res_hi_r;
    res_lo_nxt           = res_lo_r;
    ph_cnt_nxt           = ph_cnt_r;
    conv_cnt_nxt         = conv_cnt_r;
    sar_nxt              = sar_r;
    bit_idx              = 4'h9 - conv_cnt_r;
    res_wr               = wr_fire && wstrb0_r &&
                           (waddr_r == REG_RES_HI || waddr_r == REG_RES_LO);
    if (wr_fire && wstrb0_r) begin
      case (waddr_r)
        REG_CTRL: begin
          converter_enable_nxt = wdata_r[CTRL_EN_BIT];
          chan_nxt             = wdata_r[CTRL_CHAN_LSB +: 4];
          // start only counts once the converter was already on
          go_nxt = wdata_r[CTRL_GO_BIT] && wdata_r[CTRL_EN_BIT] && converter_enable_r;
        end
        REG_TIMING: begin
          fmt_nxt     = wdata_r[TIM_FMT_BIT];
          acq_sel_nxt = wdata_r[TIM_ACQ_LSB +: 3];
          clk_sel_nxt = wdata_r[TIM_CLK_LSB +: 3];
        end
        REG_RES_HI: res_hi_nxt = wdata_r;
        REG_RES_LO: res_lo_nxt = wdata_r;
        REG_STATUS: if (wdata_r[STAT_FLAG_BIT]) flag_nxt = 1'b0;
        REG_PINCFG: pincfg_nxt = wdata_r[3:0];
        default: ;
      endcase
    end
    if (!converter_enable_r) begin
      state_nxt = ST_IDLE;
      go_nxt    = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: state_nxt = ST_DISCH;
        ST_DISCH: if (tad_tick) state_nxt = ST_SAMPL;
        ST_SAMPL: begin
          if (go_r) begin
            ph_cnt_nxt = 5'h00;
            if (acq_sel_r != 3'h0) begin
              state_nxt = ST_ACQ;
            end else if (clk_sel_r[1:0] == 2'h3) begin
              state_nxt = ST_HOLD;
            end else begin
              state_nxt = ST_CONV;
            end
          end
        end
        ST_HOLD: begin
          if (!go_r) begin
            state_nxt = ST_WAIT2;
          end else if (ph_cnt_r == TCY_LAST) begin
            state_nxt = ST_CONV;
          end else begin
            ph_cnt_nxt = ph_cnt_r + 5'h01;
          end
        end
        ST_ACQ: begin
          if (!go_r) begin
            state_nxt = ST_WAIT2;
          end else if (tad_tick) begin
            if (ph_cnt_r == acq_tads(acq_sel_r) - 5'h01) begin
              state_nxt = ST_CONV;
            end else begin
              ph_cnt_nxt = ph_cnt_r + 5'h01;
            end
          end
        end
        ST_CONV: begin
          if (!go_r) begin
            state_nxt  = ST_WAIT2;
            ph_cnt_nxt = 5'h00;
          end else if (tad_tick) begin
            if (conv_cnt_r == CONV_LAST) begin
              state_nxt  = ST_WAIT2;
              ph_cnt_nxt = 5'h00;
              go_nxt     = 1'b0;
              flag_nxt   = 1'b1;
              if (fmt_r) begin
                res_hi_nxt = {6'h00, sar_r[9:8]};
                res_lo_nxt = sar_r[7:0];
              end else begin
                res_hi_nxt = sar_r[9:2];
                res_lo_nxt = {sar_r[1:0], 6'h00};
              end
            end else begin
              sar_nxt[bit_idx] = sync2_r[16];
              if (bit_idx != 4'h0) begin
                sar_nxt[bit_idx - 4'h1] = 1'b1;
              end
              conv_cnt_nxt = conv_cnt_r + 4'h1;
            end
          end
        end
        ST_WAIT2: begin
          if (tad_tick) begin
            if (ph_cnt_r == WAIT_LAST) begin
              state_nxt = ST_DISCH;
            end else begin
              ph_cnt_nxt = ph_cnt_r + 5'h01;
            end
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
    if (state_nxt == ST_CONV && state_r != ST_CONV) begin
      conv_cnt_nxt = 4'h0;
      sar_nxt      = 10'h200;
    end
    // every phase counts from zero, an aborted acquisition or hold-off included
    if (state_nxt != state_r) begin
      ph_cnt_nxt = 5'h00;
    end
    tad_restart = (state_nxt != state_r);
    // still sampling through the rc hold-off; the switch opens as conversion starts
    cap_nxt     = (state_nxt == ST_SAMPL) || (state_nxt == ST_ACQ) ||
                  (state_nxt == ST_HOLD);
    dis_nxt     = (state_nxt == ST_DISCH);
  end

  // sequencer registers; reset leaves the converter off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r            <= ST_IDLE;
      converter_enable_r <= 1'b0;
      go_r               <= 1'b0;
      chan_r             <= 4'h0;
      pincfg_r           <= 4'h0;
      fmt_r              <= 1'b0;
      flag_r             <= 1'b0;
      acq_sel_r          <= ACQ_SEL_RST;
      clk_sel_r          <= CLK_SEL_RST;
      res_hi_r           <= 8'h00;
      res_lo_r           <= 8'h00;
      ph_cnt_r           <= 5'h00;
      conv_cnt_r         <= 4'h0;
      sar_r              <= 10'h000;
      cap_r              <= 1'b0;
      dis_r              <= 1'b0;
    end else begin
      state_r            <= state_nxt;
      converter_enable_r <= converter_enable_nxt;
      go_r               <= go_nxt;
      chan_r             <= chan_nxt;
      pincfg_r           <= pincfg_nxt;
      fmt_r              <= fmt_nxt;
      flag_r             <= flag_nxt;
      acq_sel_r          <= acq_sel_nxt;
      clk_sel_r          <= clk_sel_nxt;
      res_hi_r           <= res_hi_nxt;
      res_lo_r           <= res_lo_nxt;
      ph_cnt_r           <= ph_cnt_nxt;
      conv_cnt_r         <= conv_cnt_nxt;
      sar_r              <= sar_nxt;
      cap_r              <= cap_nxt;
      dis_r              <= dis_nxt;
    end
  end

  // outputs
  assign s_axi_awready      = awready_r;
  assign s_axi_wready       = wready_r;
  assign s_axi_bvalid       = bvalid_r;
  assign s_axi_bresp        = bresp_r;
  assign s_axi_arready      = arready_r;
  assign s_axi_rvalid       = rvalid_r;
  assign s_axi_rresp        = rresp_r;
  assign s_axi_rdata        = rdata_r;
  assign cap_connect        = cap_r;
  assign array_discharge    = dis_r;
  assign sar_trial          = sar_r;
  assign channel_select     = chan_r;
  assign conv_complete_flag = flag_r;

  // helper: bit period ticks seen in the current state
  logic [4:0] ph_ticks_h;
  always_ff @(posedge aclk) begin
    if (!aresetn || tad_restart) begin
      ph_ticks_h <= 5'h00;
    end else if (tad_tick) begin
      ph_ticks_h <= ph_ticks_h + 5'h01;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_rc_manual;
    state_r == ST_SAMPL && go_r && converter_enable_r && acq_sel_r == 3'h0 &&
      clk_sel_r[1:0] == 2'h3;
  endsequence
  sequence seq_done;
    state_r == ST_CONV && go_r && converter_enable_r && tad_tick && conv_cnt_r == CONV_LAST;
  endsequence

  acq_reset_a: assert property ($rose(aresetn) |-> acq_sel_r == 3'h0)
    else $error("acquisition field not zero after reset");
  off_reset_a: assert property ($rose(aresetn) |-> state_r == ST_IDLE && !converter_enable_r)
    else $error("converter not off after reset");
  manual_start_a: assert property (state_r == ST_SAMPL && go_r && converter_enable_r &&
      acq_sel_r == 3'h0 && clk_sel_r[1:0] != 2'h3 |=> state_r == ST_CONV && !cap_r)
    else $error("manual start did not convert at once");
  rc_holdoff_a: assert property (seq_rc_manual ##1 (go_r && converter_enable_r)[*4]
      |-> state_r == ST_HOLD ##1 state_r == ST_CONV)
    else $error("rc manual start not held one instruction");
  acq_len_a: assert property (state_r == ST_ACQ && state_nxt == ST_CONV
      |-> ph_ticks_h == acq_tads(acq_sel_r) - 5'h01 && tad_tick)
    else $error("acquisition length wrong");
  acq_four_a: assert property (state_r == ST_ACQ && state_nxt == ST_CONV && acq_sel_r == 3'h2
      |-> ph_ticks_h == 5'h03)
    else $error("setting 010 not four periods");
  conv_len_a: assert property (seq_done |-> ph_ticks_h == 5'h0A)
    else $error("conversion not eleven periods");
  done_flag_a: assert property (seq_done |=> !go_r && flag_r && state_r == ST_WAIT2)
    else $error("completion did not clear start and set flag");
  just_res_a: assert property (seq_done ##0 !res_wr |=> (fmt_r ?
      (res_lo_r == $past(sar_r[7:0])) : (res_hi_r == $past(sar_r[9:2]))))
    else $error("result justification wrong");
  abort_keep_a: assert property (state_r == ST_CONV && !go_r && !res_wr
      |=> $stable(res_hi_r) && $stable(res_lo_r) && state_r != ST_CONV)
    else $error("abort changed result");
  wait_two_a: assert property (state_r == ST_WAIT2 && state_nxt == ST_DISCH
      |-> ph_ticks_h == 5'h01 && tad_tick)
    else $error("restart wait not two periods");
  cap_conv_a: assert property (state_r == ST_CONV |-> !cap_r)
    else $error("capacitor connected during conversion");
  disch_first_a: assert property ($rose(cap_r) |-> $past(dis_r))
    else $error("sampling without discharge");
  off_idle_a: assert property (!converter_enable_r |=> state_r == ST_IDLE && !go_r)
    else $error("disabled converter not idle");
  port_low_a: assert property (s_axi_arvalid && arready_r && s_axi_araddr == REG_PORT
      |=> (s_axi_rdata[15:0] & analog_mask($past(pincfg_r))) == 16'h0000)
    else $error("analog pin read high");

endmodule : acs_top
`default_nettype wire

// [testbench.sv]
// testbench: random and corner stimulus for the converter sequencer over axi4-lite.
// assumes acs_top as design; comparator and pins are driven directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acs_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, comp_hi = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [15:0] pin_in = 0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, cap, dis, flag;
  logic [31:0] rdata;
  logic [9:0] sar;
  logic [3:0] chan_o;
  logic cap_q = 0, dis_q = 0, flag_q = 0;
  int cyc = 0, t_fall, t_flag, t_rise, t_dis, t_go, err_count = 0, num_checks = 0;
  logic [31:0] lf = 32'h98ce;
  // clock generation
  always #12.5 aclk = ~aclk;
  acs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comp_hi(comp_hi),
    .pin_in(pin_in), .cap_connect(cap), .array_discharge(dis), .sar_trial(sar),
    .channel_select(chan_o), .conv_complete_flag(flag));
  // edge stamps of the sequencer outputs
  always @(posedge aclk) begin
    cyc <= cyc + 1; cap_q <= cap; dis_q <= dis; flag_q <= flag;
    if (cap_q && !cap) t_fall <= cyc;
    if (!cap_q && cap) t_rise <= cyc;
    if (!flag_q && flag) t_flag <= cyc;
    if (!dis_q && dis) t_dis <= cyc;
  end
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction : rnd
  function automatic int tad(input logic [2:0] s);
    return (s[1:0] == 2'b11) ? RC_TAD_CYC : 2 << {s[1:0], s[2]};
  endfunction : tad
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk); awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    forever begin
      @(posedge aclk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid) begin resp = bresp; bready <= 0; break; end
    end
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk); araddr <= a; arv <= 1; rready <= 1;
    forever begin
      @(posedge aclk);
      if (arv && arready) arv <= 0;
      if (rvalid) begin rd = rdata; resp = rresp; rready <= 0; break; end
    end
    check(rd, e);
  endtask : rdc
  task automatic wait_lvl(input bit use_flag);
    int k;
    for (k = 0; k < 9000 && ((use_flag ? flag : cap) !== 1'b1); k++) @(posedge aclk);
    if (k == 9000) err_count++;
  endtask : wait_lvl
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // watchdog against a hung handshake or sequencer
  initial begin
    repeat (90000) @(posedge aclk);
    err_count++;
    summarize();
  end
  initial begin
    logic [2:0] acq, clk;
    logic [3:0] ch;
    logic [9:0] r;
    logic fmt;
    int n, tt, ea, dig;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdc(REG_TIMING, 0);
    rdc(8'h3C, 0); check(resp, RESP_SLVERR);
    wr(REG_PORT, 1); check(resp, RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      r[3:0] = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : rnd();
      pin_in <= rnd();
      wr(REG_PINCFG, r[3:0]);
      repeat (4) @(posedge aclk);
      dig = (r[3:0] == 0) ? 0 : r[3:0] + 1;
      rdc(REG_PORT, {16'h0, pin_in & ~(16'hFFFF >> dig)});
    end
    $display("port test done");
    wr(REG_CTRL, 32'h02); rdc(REG_CTRL, 0);
    wr(REG_CTRL, 32'h03); rdc(REG_CTRL, 32'h01);
    for (int i = 0; i < 9; i++) begin
      acq = 3'(i * 3); fmt = rnd(); ch = rnd(); comp_hi <= rnd();
      clk = (i == 8) ? 3'h4 : 3'(i * 5 + 3);
      wr(REG_TIMING, {fmt, 1'b0, acq, clk});
      wr(REG_CTRL, {ch, 2'b01});
      wait_lvl(0);
      wr(REG_CTRL, {ch, 2'b11});
      t_go = cyc;
      rdc(REG_CTRL, {ch, 2'b11});
      wait_lvl(1); wait_lvl(0);
      @(posedge aclk);
      tt = tad(clk); n = (acq == 0) ? 0 : (acq < 4) ? 2 * acq : 4 * acq - 8;
      ea = n * tt + ((clk[1:0] == 2'b11 && acq == 0) ? 4 : 0);
      check(t_fall - t_go >= ea - 2 && t_fall - t_go <= ea + tt + 6, 1);
      check(t_flag - t_fall >= 11 * tt - 2 && t_flag - t_fall <= 11 * tt + 3, 1);
      check(t_rise - t_flag >= 3 * tt - 1 && t_rise - t_flag <= 3 * tt + 3, 1);
      check(t_dis > t_flag && t_dis < t_rise, 1);
      check(chan_o, ch);
      rdc(REG_CTRL, {ch, 2'b01});
      rdc(REG_STATUS, 1);
      r = comp_hi ? 10'h3FF : 10'h000;
      check(sar, r);
      rdc(REG_RES_HI, fmt ? r[9:8] : r[9:2]);
      rdc(REG_RES_LO, fmt ? r[7:0] : {r[1:0], 6'h0});
      wr(REG_STATUS, 1); rdc(REG_STATUS, 0);
    end
    $display("conversion test done");
    wr(REG_RES_HI, 32'h5A); wr(REG_RES_LO, 32'hA5);
    // abort once in acquisition, once in the first bit period of a slow conversion
    for (int i = 0; i < 2; i++) begin
      wr(REG_TIMING, i ? 32'h06 : 32'h38);
      wr(REG_CTRL, 32'h03);
      repeat (20) @(posedge aclk);
      wr(REG_CTRL, 32'h01);
      repeat (300) @(posedge aclk);
      rdc(REG_RES_HI, 32'h5A); rdc(REG_RES_LO, 32'hA5); rdc(REG_STATUS, 0);
    end
    wr(REG_CTRL, 32'h03);
    repeat (10) @(posedge aclk);
    aresetn <= 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdc(REG_CTRL, 0); rdc(REG_TIMING, 0);
    check(cap, 0);
    $display("abort and reset test done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
